// ===== hdl/sers_ctl.sv
// controller end: makes the serial clock, runs current and random reads
`timescale 1ns/1ps
`default_nettype none
module sers_ctl import sers_pkg::*; #(
  parameter int QTR_CYC = SCL_QTR_CYC,
  parameter logic [3:0] DEV_TYPE = SERS_DEV_TYPE
) (
  input wire logic core_clk,
  input wire logic rst_n,
  sers_if.ctl link,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic cmd_random,
  input wire logic [ARR_ADDR_W-1:0] cmd_addr,
  input wire logic [7:0] cmd_count,
  input wire logic [1:0] cmd_cs,
  output logic rd_valid,
  output logic [7:0] rd_data,
  output logic done,
  output logic nacked
);
  if (QTR_CYC < 2 || QTR_CYC > 255) begin : g_chk
    $error("sers_ctl: QTR_CYC must lie between 2 and 255");
  end

  localparam logic [7:0] QTR_LAST = 8'(QTR_CYC - 1);
  localparam logic [3:0] LAST_BIT = 4'(BYTE_BITS - 1);
  localparam logic [3:0] ACK_BIT = 4'(BYTE_BITS);

  sers_ctl_st_t st_q;
  sers_ctl_st_t st_d;
  logic [7:0] cnt_q;
  logic [1:0] qtr_q;
  logic [3:0] bit_q;
  logic [3:0] bit_d;
  logic [7:0] sh_q;
  logic [7:0] sh_d;
  logic [1:0] ph_q;
  logic [1:0] ph_d;
  logic [7:0] left_q;
  logic [7:0] left_d;
  logic [ARR_ADDR_W-1:0] addr_q;
  logic [1:0] cs_q;
  logic scl_q;
  logic scl_d;
  logic oe_q;
  logic oe_d;
  logic ack_q;
  logic ack_d;
  logic rdv_d;
  logic [7:0] rdd_d;
  logic done_d;
  logic nack_d;
  logic sda_m_q;
  logic sda_s_q;

  wire idle = (st_q == C_IDLE);
  wire take = idle & cmd_valid;
  wire tick = ~idle && (cnt_q == QTR_LAST);
  wire [1:0] ph_nx = (ph_q == IDX_HI) ? IDX_LO : IDX_HI;
  wire [7:0] dev_byte = {DEV_TYPE, cs_q, addr_q[ARR_ADDR_W-1], 1'b0};
  wire [7:0] byte_nx = (ph_nx == IDX_HI) ? addr_q[15:8] : addr_q[7:0];
  wire [7:0] start_byte = (ph_q == IDX_DATA) ? (dev_byte | 8'h01) : dev_byte;

  always_comb begin
    st_d = st_q;
    bit_d = bit_q;
    sh_d = sh_q;
    ph_d = ph_q;
    left_d = left_q;
    scl_d = scl_q;
    oe_d = oe_q;
    ack_d = ack_q;
    rdv_d = 1'b0;
    rdd_d = rd_data;
    done_d = 1'b0;
    nack_d = nacked;
    if (take) begin
      st_d = C_START;
      ph_d = cmd_random ? IDX_DEV : IDX_DATA;
      left_d = (cmd_count == 8'h00) ? 8'h01 : cmd_count;
      nack_d = 1'b0;
    end else if (tick) begin
      if (qtr_q == 2'h0) begin
        scl_d = 1'b1;
      end
      if (qtr_q == 2'h2 && st_q != C_STOP) begin
        scl_d = 1'b0;
      end
      case (st_q)
        C_START: begin
          if (qtr_q == 2'h1) begin
            oe_d = 1'b1;
          end
          if (qtr_q == 2'h3) begin
            sh_d = start_byte;
            oe_d = ~start_byte[7];
            bit_d = 4'h0;
            st_d = C_TX;
          end
        end
        C_TX: begin
          if (qtr_q == 2'h1) begin
            ack_d = (sda_s_q == ACK_LEVEL);
          end
          if (qtr_q == 2'h3) begin
            if (bit_q == ACK_BIT) begin
              bit_d = 4'h0;
              if (!ack_q) begin
                nack_d = 1'b1;
                oe_d = 1'b1;
                st_d = C_STOP;
              end else if (ph_q == IDX_LO) begin
                oe_d = 1'b0;
                ph_d = IDX_DATA;
                st_d = C_START;
              end else if (ph_q == IDX_DATA) begin
                oe_d = 1'b0;
                st_d = C_RX;
              end else begin
                ph_d = ph_nx;
                sh_d = byte_nx;
                oe_d = ~byte_nx[7];
              end
            end else if (bit_q == LAST_BIT) begin
              oe_d = 1'b0;
              bit_d = ACK_BIT;
            end else begin
              sh_d = {sh_q[6:0], 1'b0};
              oe_d = ~sh_q[6];
              bit_d = bit_q + 4'h1;
            end
          end
        end
        C_RX: begin
          if (qtr_q == 2'h1 && bit_q != ACK_BIT) begin
            sh_d = {sh_q[6:0], sda_s_q};
          end
          if (qtr_q == 2'h3) begin
            if (bit_q == LAST_BIT) begin
              bit_d = ACK_BIT;
              oe_d = (left_q > 8'h01);
              rdv_d = 1'b1;
              rdd_d = sh_q;
              left_d = left_q - 8'h01;
            end else if (bit_q == ACK_BIT) begin
              bit_d = 4'h0;
              oe_d = (left_q == 8'h00);
              st_d = (left_q == 8'h00) ? C_STOP : C_RX;
            end else begin
              bit_d = bit_q + 4'h1;
            end
          end
        end
        C_STOP: begin
          if (qtr_q == 2'h1) begin
            oe_d = 1'b0;
          end
          if (qtr_q == 2'h3) begin
            st_d = C_IDLE;
            done_d = 1'b1;
          end
        end
        default: begin
          st_d = C_IDLE;
          oe_d = 1'b0;
          scl_d = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sda_m_q <= 1'b1;
      sda_s_q <= 1'b1;
      cnt_q <= 8'h00;
      qtr_q <= 2'h0;
      addr_q <= '0;
      cs_q <= 2'h0;
    end else begin
      sda_m_q <= link.sda;
      sda_s_q <= sda_m_q;
      cnt_q <= (tick || idle) ? 8'h00 : cnt_q + 8'h01;
      qtr_q <= idle ? 2'h0 : (tick ? qtr_q + 2'h1 : qtr_q);
      if (take) begin
        addr_q <= cmd_addr;
        cs_q <= cmd_cs;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= C_IDLE;
      bit_q <= 4'h0;
      sh_q <= 8'h00;
      ph_q <= IDX_DEV;
      left_q <= 8'h00;
      scl_q <= 1'b1;
      oe_q <= 1'b0;
      ack_q <= 1'b0;
      rd_valid <= 1'b0;
      rd_data <= 8'h00;
      done <= 1'b0;
      nacked <= 1'b0;
    end else begin
      st_q <= st_d;
      bit_q <= bit_d;
      sh_q <= sh_d;
      ph_q <= ph_d;
      left_q <= left_d;
      scl_q <= scl_d;
      oe_q <= oe_d;
      ack_q <= ack_d;
      rd_valid <= rdv_d;
      rd_data <= rdd_d;
      done <= done_d;
      nacked <= nack_d;
    end
  end

  assign cmd_ready = idle;
  assign link.scl = scl_q;
  assign link.ctl_sda_o = 1'b0;
  assign link.ctl_sda_oe = oe_q;
endmodule
`default_nettype wire

// ===== hdl/sers_dev.sv
// memory device end: address decode, counter, sequential and random reads
`timescale 1ns/1ps
`default_nettype none
module sers_dev import sers_pkg::*; #(
  parameter int ADDR_W = ARR_ADDR_W,
  parameter logic [3:0] DEV_TYPE = SERS_DEV_TYPE
) (
  input wire logic core_clk,
  input wire logic rst_n,
  sers_if.dev link,
  input wire logic chip_select_hi,
  input wire logic chip_select_lo,
  input wire logic mem_wr_en,
  input wire logic [ADDR_W-1:0] mem_wr_addr,
  input wire logic [7:0] mem_wr_data,
  output logic [ADDR_W-1:0] cur_addr,
  output logic busy
);
  localparam int DEPTH = 1 << ADDR_W;
  localparam logic [ADDR_W-1:0] MAX_ADDR = ADDR_W'(DEPTH - 1);
  localparam logic [3:0] LAST_BIT = 4'(BYTE_BITS - 1);
  localparam logic [3:0] FULL_BYTE = 4'(BYTE_BITS);

  if (ADDR_W < 9 || ADDR_W > ARR_ADDR_W) begin : g_chk
    $error("sers_dev: ADDR_W must lie between 9 and 17");
  end

  logic [7:0] mem [0:DEPTH-1];

  logic scl_m_q;
  logic scl_s_q;
  logic scl_d_q;
  logic sda_m_q;
  logic sda_s_q;
  logic sda_d_q;
  logic [1:0] cs_m_q;
  logic [1:0] cs_s_q;

  sers_dev_st_t st_q;
  sers_dev_st_t st_d;
  logic [3:0] bit_q;
  logic [3:0] bit_d;
  logic [1:0] idx_q;
  logic [1:0] idx_d;
  logic [7:0] rx_q;
  logic [7:0] rx_d;
  logic [7:0] tx_q;
  logic [7:0] tx_d;
  logic [7:0] hi_q;
  logic [7:0] hi_d;
  logic oe_q;
  logic oe_d;
  logic rw_q;
  logic rw_d;
  logic page_q;
  logic page_d;
  logic [ADDR_W-1:0] addr_q;
  logic [ADDR_W-1:0] addr_d;

  wire scl_rise = scl_s_q & ~scl_d_q;
  wire scl_fall = ~scl_s_q & scl_d_q;
  wire start_ev = scl_s_q & scl_d_q & sda_d_q & ~sda_s_q;
  wire stop_ev = scl_s_q & scl_d_q & ~sda_d_q & sda_s_q;
  wire byte_done = scl_fall && (bit_q == FULL_BYTE);
  wire id_match = (rx_q[TYPE_LSB+:4] == DEV_TYPE) &&
                  (rx_q[CS_HI_BIT] == cs_s_q[1]) &&
                  (rx_q[CS_LO_BIT] == cs_s_q[0]);
  wire ack_ok = (idx_q != IDX_DEV) || id_match;
  wire [ARR_ADDR_W-1:0] full_addr = {page_q, hi_q, rx_q};
  wire [ADDR_W-1:0] load_addr = full_addr[ADDR_W-1:0];
  wire [ADDR_W-1:0] addr_inc = (addr_q == MAX_ADDR) ? '0 : addr_q + 1'b1;
  wire [7:0] rd_byte = mem[addr_q];

  // backdoor preload of the array
  always_ff @(posedge core_clk) begin
    if (mem_wr_en) begin
      mem[mem_wr_addr] <= mem_wr_data;
    end
  end

  // pins pass two flops; third stage only for edge finding
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_m_q <= 1'b1;
      scl_s_q <= 1'b1;
      scl_d_q <= 1'b1;
      sda_m_q <= 1'b1;
      sda_s_q <= 1'b1;
      sda_d_q <= 1'b1;
      cs_m_q <= 2'h0;
      cs_s_q <= 2'h0;
    end else begin
      scl_m_q <= link.scl;
      scl_s_q <= scl_m_q;
      scl_d_q <= scl_s_q;
      sda_m_q <= link.sda;
      sda_s_q <= sda_m_q;
      sda_d_q <= sda_s_q;
      cs_m_q <= {chip_select_hi, chip_select_lo};
      cs_s_q <= cs_m_q;
    end
  end

  always_comb begin
    st_d = st_q;
    bit_d = bit_q;
    idx_d = idx_q;
    rx_d = rx_q;
    tx_d = tx_q;
    hi_d = hi_q;
    oe_d = oe_q;
    rw_d = rw_q;
    page_d = page_q;
    addr_d = addr_q;
    if (stop_ev) begin
      st_d = D_IDLE;
      oe_d = 1'b0;
    end else if (start_ev) begin
      // a start anywhere drops a pending write and decodes anew
      st_d = D_RX;
      bit_d = 4'h0;
      idx_d = IDX_DEV;
      oe_d = 1'b0;
    end else begin
      case (st_q)
        D_IDLE: begin
          oe_d = 1'b0;
        end
        D_RX: begin
          if (scl_rise && bit_q != FULL_BYTE) begin
            rx_d = {rx_q[6:0], sda_s_q};
            bit_d = bit_q + 4'h1;
          end else if (byte_done) begin
            if (ack_ok) begin
              oe_d = 1'b1;
              st_d = D_ACK;
            end else begin
              st_d = D_IDLE;
            end
            if (idx_q == IDX_DEV) begin
              rw_d = rx_q[RW_BIT];
              page_d = rx_q[PAGE_BIT];
            end
            if (idx_q == IDX_HI) begin
              hi_d = rx_q;
            end
            if (idx_q == IDX_LO) begin
              addr_d = load_addr;
            end
          end
        end
        D_ACK: begin
          if (scl_fall) begin
            oe_d = 1'b0;
            if (rw_q) begin
              // first or further byte of a read
              tx_d = rd_byte;
              oe_d = ~rd_byte[7];
              bit_d = 4'h0;
              addr_d = addr_inc;
              st_d = D_TX;
            end else begin
              st_d = D_RX;
              bit_d = 4'h0;
              if (idx_q != IDX_DATA) begin
                idx_d = idx_q + 2'h1;
              end
            end
          end
        end
        D_TX: begin
          if (scl_fall) begin
            if (bit_q == LAST_BIT) begin
              oe_d = 1'b0;
              st_d = D_MACK;
            end else begin
              tx_d = {tx_q[6:0], 1'b0};
              oe_d = ~tx_q[6];
              bit_d = bit_q + 4'h1;
            end
          end
        end
        D_MACK: begin
          if (scl_rise) begin
            // low means another byte; high leaves the line alone
            st_d = (sda_s_q == ACK_LEVEL) ? D_ACK : D_IDLE;
          end
        end
        default: begin
          st_d = D_IDLE;
          oe_d = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= D_IDLE;
      bit_q <= 4'h0;
      idx_q <= IDX_DEV;
      rx_q <= 8'h00;
      tx_q <= 8'h00;
      hi_q <= 8'h00;
      oe_q <= 1'b0;
      rw_q <= 1'b0;
      page_q <= 1'b0;
      addr_q <= '0;
    end else begin
      st_q <= st_d;
      bit_q <= bit_d;
      idx_q <= idx_d;
      rx_q <= rx_d;
      tx_q <= tx_d;
      hi_q <= hi_d;
      oe_q <= oe_d;
      rw_q <= rw_d;
      page_q <= page_d;
      addr_q <= addr_d;
    end
  end

  assign link.dev_sda_o = 1'b0;
  assign link.dev_sda_oe = oe_q;
  assign cur_addr = addr_q;
  assign busy = (st_q != D_IDLE);
endmodule
`default_nettype wire

// ===== hdl/sers_if.sv
// two-wire link between controller and memory device
`timescale 1ns/1ps
`default_nettype none
interface sers_if;
  logic scl;
  logic sda;
  logic ctl_sda_o;
  logic ctl_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  // wired-and of the open-drain drivers, pulled high otherwise
  assign sda = ~((ctl_sda_oe & ~ctl_sda_o) | (dev_sda_oe & ~dev_sda_o));
  modport dev (input scl, input sda, output dev_sda_o, output dev_sda_oe);
  modport ctl (output scl, input sda, output ctl_sda_o, output ctl_sda_oe);
endinterface
`default_nettype wire

// ===== hdl/sers_pkg.sv
// constants and types shared by both ends of the serial memory read link
`default_nettype none
package sers_pkg;
  localparam int ARR_ADDR_W = 17;
  localparam int BYTE_BITS = 8;
  localparam logic [3:0] SERS_DEV_TYPE = 4'h5; // value is arbitrary
  localparam int RW_BIT = 0;
  localparam int PAGE_BIT = 1;
  localparam int CS_LO_BIT = 2;
  localparam int CS_HI_BIT = 3;
  localparam int TYPE_LSB = 4;
  localparam logic ACK_LEVEL = 1'b0;
  localparam logic [1:0] IDX_DEV = 2'h0;
  localparam logic [1:0] IDX_HI = 2'h1;
  localparam logic [1:0] IDX_LO = 2'h2;
  localparam logic [1:0] IDX_DATA = 2'h3;
  localparam int CORE_CLK_PERIOD_NS = 50;
  localparam int SCL_PERIOD_NS = 400;
  localparam int SCL_QTR_CYC = SCL_PERIOD_NS / (4 * CORE_CLK_PERIOD_NS);

  typedef enum logic [4:0] {
    D_IDLE = 5'h01,
    D_RX = 5'h02,
    D_ACK = 5'h04,
    D_TX = 5'h08,
    D_MACK = 5'h10
  } sers_dev_st_t;

  typedef enum logic [4:0] {
    C_IDLE = 5'h01,
    C_START = 5'h02,
    C_TX = 5'h04,
    C_RX = 5'h08,
    C_STOP = 5'h10
  } sers_ctl_st_t;
endpackage
`default_nettype wire

// ===== verification/sers_monitor.sv
// wire-level checks on the two-wire read link
`timescale 1ns/1ps
`default_nettype none
module sers_monitor import sers_pkg::*; #(
  parameter logic [1:0] STRAP = 2'h2
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic scl,
  input wire logic sda,
  input wire logic ctl_sda_o,
  input wire logic ctl_sda_oe,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe
);
  logic scl_q, sda_q, rise, start, hit_sh, hit_fb;
  logic [7:0] sh_q, fb_q;
  logic [15:0] cnt_q;
  assign rise = scl & ~scl_q;
  assign start = scl & scl_q & sda_q & ~sda;
  assign hit_sh = (sh_q[7:2] == {SERS_DEV_TYPE, STRAP});
  assign hit_fb = (fb_q[7:2] == {SERS_DEV_TYPE, STRAP});
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
    end
  end
  // clock rises since the last start, and the bits seen on them
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 16'h0;
      sh_q <= 8'h0;
    end else if (start) begin
      cnt_q <= 16'h0;
    end else if (rise) begin
      cnt_q <= cnt_q + 16'h1;
      sh_q <= {sh_q[6:0], sda};
    end
  end
  // address byte of the current frame
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      fb_q <= 8'h0;
    end else if (rise && cnt_q == 16'h8) begin
      fb_q <= sh_q;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence s_stop;
    scl && scl_q && !sda_q && sda;
  endsequence
  sequence s_quiet;
    !dev_sda_oe [*8];
  endsequence
  property p_oe_scl_low;
    $changed(dev_sda_oe) |-> !scl;
  endproperty
  property p_addr_quiet;
    rise && cnt_q < 16'h8 |-> !dev_sda_oe;
  endproperty
  property p_ack_9th;
    rise && cnt_q == 16'h8 && hit_sh |-> dev_sda_oe;
  endproperty
  property p_nack_mismatch;
    rise && cnt_q == 16'h8 && !hit_sh |-> !dev_sda_oe;
  endproperty
  property p_wr_ack;
    rise && (cnt_q == 16'd17 || cnt_q == 16'd26) && !fb_q[0] && hit_fb |-> dev_sda_oe;
  endproperty
  property p_rd_release;
    rise && cnt_q > 16'h8 && cnt_q % 9 == 8 && fb_q[0] && hit_fb |-> !dev_sda_oe;
  endproperty
  property p_stop_idle;
    s_stop |=> s_quiet;
  endproperty
  property p_ctl_excl;
    scl && ctl_sda_oe |-> !dev_sda_oe;
  endproperty
  property p_open_drain;
    !ctl_sda_o && !dev_sda_o;
  endproperty
  a_oe_scl_low: assert property (p_oe_scl_low) else $error("data moved with clock high");
  a_addr_quiet: assert property (p_addr_quiet) else $error("device drove address bits");
  a_ack_9th: assert property (p_ack_9th) else $error("no ack on address");
  a_nack_mismatch: assert property (p_nack_mismatch) else $error("ack on bad address");
  a_wr_ack: assert property (p_wr_ack) else $error("no ack on word address");
  a_rd_release: assert property (p_rd_release) else $error("line held in host ack");
  a_stop_idle: assert property (p_stop_idle) else $error("device drove after stop");
  a_ctl_excl: assert property (p_ctl_excl) else $error("both ends drive low");
  a_open_drain: assert property (p_open_drain) else $error("data output not low");
endmodule
`default_nettype wire

// ===== verification/tb_serial_eeprom_read_sequencer.sv
// self-checking bench: controller and memory device joined by the link
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) \
  begin \
    n_compared++; \
    if ((a) !== (b)) begin \
      n_errors++; \
      $display("ERROR %0t: got %0h exp %0h", $time, a, b); \
    end \
  end
module tb_serial_eeprom_read_sequencer;
  import sers_pkg::*;
  logic core_clk, rst_n, cmd_valid, cmd_ready, cmd_random, rd_valid, done, nacked, busy;
  logic mem_wr_en;
  logic [16:0] cmd_addr, mem_wr_addr, cur_addr, ptr;
  logic [7:0] cmd_count, rd_data, mem_wr_data, wsh;
  logic [1:0] cmd_cs;
  int n_errors, n_compared, cyc;
  sers_if lnk();
  sers_ctl sers_ctl_i(.core_clk(core_clk), .rst_n(rst_n), .link(lnk), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_random(cmd_random), .cmd_addr(cmd_addr), .cmd_count(cmd_count),
    .cmd_cs(cmd_cs), .rd_valid(rd_valid), .rd_data(rd_data), .done(done), .nacked(nacked));
  sers_dev sers_dev_i(.core_clk(core_clk), .rst_n(rst_n), .link(lnk), .chip_select_hi(1'b1),
    .chip_select_lo(1'b0), .mem_wr_en(mem_wr_en), .mem_wr_addr(mem_wr_addr),
    .mem_wr_data(mem_wr_data), .cur_addr(cur_addr), .busy(busy));
  sers_monitor #(.STRAP(2'h2)) sers_monitor_i(.core_clk(core_clk), .rst_n(rst_n), .scl(lnk.scl),
    .sda(lnk.sda), .ctl_sda_o(lnk.ctl_sda_o), .ctl_sda_oe(lnk.ctl_sda_oe),
    .dev_sda_o(lnk.dev_sda_o), .dev_sda_oe(lnk.dev_sda_oe));
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  // bits as they cross the wire, first one in at the top
  always @(posedge lnk.scl) begin
    wsh <= {wsh[6:0], lnk.sda};
  end
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      end_sim();
    end
  end
  function automatic logic [7:0] pat(input logic [16:0] a);
    return a[7:0] ^ a[15:8] ^ {a[16], 7'h29};
  endfunction
  task automatic end_sim;
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic preload(input logic [16:0] a, input int n);
    for (int i = 0; i < n; i++) begin
      @(negedge core_clk);
      mem_wr_en = 1'b1;
      mem_wr_addr = a + 17'(i);
      mem_wr_data = pat(a + 17'(i));
    end
    @(negedge core_clk);
    mem_wr_en = 1'b0;
  endtask
  task automatic run(input logic rnd, input logic [16:0] a, input int n, input logic [1:0] cs);
    logic ok;
    int k;
    int t;
    ok = (cs == 2'h2);
    if (rnd && ok) ptr = a;
    k = 0;
    t = 0;
    @(negedge core_clk);
    cmd_valid = 1'b1;
    cmd_random = rnd;
    cmd_addr = a;
    cmd_count = 8'(n);
    cmd_cs = cs;
    @(negedge core_clk);
    cmd_valid = 1'b0;
    while (done !== 1'b1 && t < 3000) begin
      @(negedge core_clk);
      t++;
      if (rd_valid === 1'b1) begin
        `CHK(rd_data, pat(ptr))
        `CHK(wsh, pat(ptr))
        ptr = ptr + 17'h1;
        k++;
      end
    end
    `CHK(done, 1'b1)
    `CHK(k, ok ? ((n == 0) ? 1 : n) : 0)
    `CHK(nacked, ~ok)
    `CHK(busy, 1'b0)
    `CHK(cur_addr, ptr)
    `CHK(lnk.scl, 1'b1)
    `CHK(lnk.sda, 1'b1)
  endtask
  initial begin
    rst_n = 1'b0;
    cmd_valid = 1'b0;
    cmd_random = 1'b0;
    cmd_addr = 17'h0;
    cmd_count = 8'h0;
    cmd_cs = 2'h0;
    mem_wr_en = 1'b0;
    mem_wr_addr = 17'h0;
    mem_wr_data = 8'h0;
    ptr = 17'h0;
    repeat (20) @(negedge core_clk);
    rst_n = 1'b1;
    `CHK(cur_addr, 17'h0)
    `CHK(cmd_ready, 1'b1)
    preload(17'h12345, 6);
    preload(17'h1fffe, 2);
    preload(17'h00000, 2);
    preload(17'h000ff, 3);
    run(1'b1, 17'h12345, 4, 2'h2);
    run(1'b0, 17'h0, 2, 2'h2);
    run(1'b1, 17'h1fffe, 3, 2'h2);
    run(1'b1, 17'h000ff, 1, 2'h2);
    run(1'b0, 17'h0, 1, 2'h1);
    run(1'b1, 17'h12346, 1, 2'h0);
    run(1'b0, 17'h0, 1, 2'h2);
    run(1'b0, 17'h0, 0, 2'h2);
    end_sim();
  end
endmodule
`default_nettype wire
